// ==== test/cemb_mem_model.sv ====
/*
  memory-side model of the pin bus: free-running mclk, a 16-word memory,
  wait states, abort and latch gate on the bench's command.
  assumes hclk of 8 ns; addr_out[5:2] selects the word.
*/
module cemb_mem_model (
  input wire logic hclk,
  input wire logic [31:0] addr_out,
  input wire logic write_not_read,
  input wire logic memory_request_n,
  input wire logic core_fast_sel,
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  input wire logic ale_en,
  input wire logic abort_req,
  input wire logic [3:0] wait_req,
  output logic mclk,
  output logic ale,
  output logic cycle_extend_n,
  output logic abort,
  output logic [31:0] data_in,
  output logic [31:0] last_wr,
  output logic [7:0] wr_cnt,
  output logic [3:0] ext_cnt,
  output logic bad_oe,
  output logic slow_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [16];
  logic [31:0] last_drv;
  logic [3:0] ext_left;
  logic oe_q;
  // mclk runs free, so slow accesses use the extend pin instead
  initial begin
    mclk = 1'b0;
    forever #48 mclk = ~mclk;
  end
  // known contents so a read never returns an unknown
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'hC0DE_0000 | i;
    last_drv = 32'h0;
    cycle_extend_n = 1'b1;
    ext_left = 4'h0;
    {ext_cnt, wr_cnt, bad_oe, slow_seen, oe_q, last_wr} = '0;
  end
  assign ale = ale_en;
  assign abort = abort_req; // held as commanded, idle or not
  // read data stands while the request is low on a read; else a pattern toggling each cycle
  assign data_in = (!memory_request_n && !write_not_read) ? mem[addr_out[5:2]] : ~last_drv;
  // capture writes and watch the drive and clock-select pins
  always @(posedge hclk) begin
    last_drv <= data_in;
    oe_q <= data_oe;
    if (data_oe) begin
      mem[addr_out[5:2]] <= data_out;
      last_wr <= data_out;
    end
    if (data_oe && !oe_q) wr_cnt <= wr_cnt + 8'h01;
    if (data_oe && !write_not_read) bad_oe <= 1'b1;
    if (!memory_request_n && !core_fast_sel) slow_seen <= 1'b1;
  end
  // extend goes low in the low phase before the access cycle
  always @(negedge memory_request_n) begin
    ext_cnt = 4'h0;
    ext_left = wait_req;
    if (wait_req != 4'h0) cycle_extend_n = 1'b0;
  end
  // released two hclk after a fall, still inside the low phase
  // ext_cnt counts falls under a low request, so it shows the waits the design took plus the completing fall
  always @(negedge mclk) begin
    if (!memory_request_n) ext_cnt = ext_cnt + 4'h1;
    if (!cycle_extend_n) begin
      #16;
      ext_left = ext_left - 4'h1;
      if (ext_left == 4'h0) cycle_extend_n = 1'b1;
    end
  end
  // no other master exists here, so lock is never contested
endmodule : cemb_mem_model

// ==== test/cemb_top_tb_top.sv ====
/*
  self-checking bench: ahb-lite tasks queue accesses, the memory model
  answers on the pin bus. assumes no other master on either bus.
*/
module cemb_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv, addr_out, data_in, data_out, last_wr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic mclk, ale, cycle_extend_n, abort, address_drive_enable, data_drive_enable;
  logic write_not_read, word_not_byte, lock, addr_grp_oe, memory_request_n;
  logic core_fast_sel, data_oe, ale_en, abort_req, bad_oe, slow_seen;
  logic [3:0] wait_req, ext_cnt;
  logic [7:0] wr_cnt, wc;
  logic [6:0] pins;
  int n_errors, total_checks, cyc;
  assign pins = {lock, write_not_read, word_not_byte, core_fast_sel, data_oe, irq,
    memory_request_n};
  cemb_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .mclk(mclk),
    .ale(ale), .cycle_extend_n(cycle_extend_n), .abort(abort),
    .address_drive_enable(address_drive_enable), .data_drive_enable(data_drive_enable),
    .addr_out(addr_out), .write_not_read(write_not_read), .word_not_byte(word_not_byte),
    .lock(lock), .addr_grp_oe(addr_grp_oe), .memory_request_n(memory_request_n),
    .core_fast_sel(core_fast_sel), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));
  cemb_mem_model u_mem (.hclk(hclk), .addr_out(addr_out), .write_not_read(write_not_read),
    .memory_request_n(memory_request_n), .core_fast_sel(core_fast_sel),
    .data_out(data_out), .data_oe(data_oe), .ale_en(ale_en), .abort_req(abort_req),
    .wait_req(wait_req), .mclk(mclk), .ale(ale), .cycle_extend_n(cycle_extend_n),
    .abort(abort), .data_in(data_in), .last_wr(last_wr), .wr_cnt(wr_cnt),
    .ext_cnt(ext_cnt), .bad_oe(bad_oe), .slow_seen(slow_seen));
  task automatic conclude;
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // address phase held until hready, then idle for the data phase
  task automatic ap(input logic [7:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
  endtask : ap
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ap(a, 1'b1);
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ap(a, 1'b0);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask : rd
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, rdv);
  endtask : rdc
  // poll until neither busy (bit 0) nor pending (bit 2)
  task automatic wait_idle;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 60; i++) begin
      rd(cemb_pkg::CEMB_OFS_STATUS);
      if (rdv[0] === 1'b0 && rdv[2] === 1'b0) break;
    end
    chk("idle", 32'h0, rdv & 32'h5);
    repeat (4) @(posedge hclk);
  endtask : wait_idle
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // hang guard: the whole sequence needs a few hundred cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, abort_req, wait_req, hresetn, cyc} = '0;
    hsize = 3'h2;
    address_drive_enable = 1'b1;
    data_drive_enable = 1'b1; // no bus sharing, high except for the dbe_block write
    ale_en = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("reset_pins", 7'h19, pins);
    chk("reset_oe", 1'b1, addr_grp_oe);
    chk("ahb_resp", 2'h2, {hreadyout, hresp});
    rdc("ctrl", cemb_pkg::CEMB_OFS_CTRL, 32'h4);
    rdc("status", cemb_pkg::CEMB_OFS_STATUS, 32'h8);
    rdc("irq_mask", cemb_pkg::CEMB_OFS_IRQ_MASK, 32'h0);
    wr(cemb_pkg::CEMB_OFS_RDATA, 32'hFFFF_FFFF);
    rdc("rdata_ro", cemb_pkg::CEMB_OFS_RDATA, 32'h0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h1C, 32'h0);
    // locked word write; the address write while busy must be refused
    wr(cemb_pkg::CEMB_OFS_IRQ_MASK, 32'h3);
    wr(cemb_pkg::CEMB_OFS_ADDR, 32'h24);
    wr(cemb_pkg::CEMB_OFS_WDATA, 32'hA5A5_1234);
    wr(cemb_pkg::CEMB_OFS_CTRL, 32'hF);
    wr(cemb_pkg::CEMB_OFS_ADDR, 32'h0);
    wait_idle();
    chk("wr_data", 32'hA5A5_1234, last_wr);
    chk("addr", 32'h24, addr_out);
    chk("wr_pins", 7'h7B, pins);
    chk("slow_core", 1'b1, slow_seen);
    rdc("done", cemb_pkg::CEMB_OFS_IRQ_STAT, 32'h1);
    // unlocked byte read with two wait states
    wait_req <= 4'h2;
    wr(cemb_pkg::CEMB_OFS_CTRL, 32'h1);
    wait_idle();
    wait_req <= 4'h0;
    rdc("rdata", cemb_pkg::CEMB_OFS_RDATA, 32'hA5A5_1234);
    chk("waits", 4'h3, ext_cnt); // completing fall plus two waits
    chk("rd_pins", 7'h0B, pins);
    wr(cemb_pkg::CEMB_OFS_IRQ_STAT, 32'h3);
    // abort held while idle is ignored, during an access it is reported
    abort_req <= 1'b1;
    repeat (40) @(posedge hclk);
    rdc("idle_abort", cemb_pkg::CEMB_OFS_IRQ_STAT, 32'h0);
    wr(cemb_pkg::CEMB_OFS_CTRL, 32'h5);
    wait_idle();
    abort_req <= 1'b0;
    rdc("abort_st", cemb_pkg::CEMB_OFS_STATUS, 32'hA);
    rd(cemb_pkg::CEMB_OFS_IRQ_STAT);
    chk("abort_irq", 1'b1, rdv[1]);
    wr(cemb_pkg::CEMB_OFS_IRQ_STAT, 32'h3);
    // latch gate low holds the old address; masked done leaves irq low
    wr(cemb_pkg::CEMB_OFS_IRQ_MASK, 32'h0);
    ale_en <= 1'b0;
    wr(cemb_pkg::CEMB_OFS_ADDR, 32'h30);
    wr(cemb_pkg::CEMB_OFS_CTRL, 32'h5);
    wait_idle();
    chk("held_addr", 32'h24, addr_out);
    chk("masked_irq", 1'b0, irq);
    rdc("masked_st", cemb_pkg::CEMB_OFS_IRQ_STAT, 32'h1);
    ale_en <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("open_addr", 32'h30, addr_out);
    // write with data drive disabled must not reach the memory
    wc = wr_cnt;
    data_drive_enable <= 1'b0;
    wr(cemb_pkg::CEMB_OFS_WDATA, 32'h5A5A_0F0F);
    wr(cemb_pkg::CEMB_OFS_CTRL, 32'h7);
    wait_idle();
    chk("dbe_block", wc, wr_cnt);
    data_drive_enable <= 1'b1;
    wr(cemb_pkg::CEMB_OFS_CTRL, 32'h7);
    wait_idle();
    chk("wr_count", wc + 8'h01, wr_cnt);
    wr(cemb_pkg::CEMB_OFS_CTRL, 32'h5);
    wait_idle();
    rdc("rdback", cemb_pkg::CEMB_OFS_RDATA, 32'h5A5A_0F0F);
    chk("oe_reads", 1'b0, bad_oe);
    // address group floats at once, between clock edges
    address_drive_enable <= 1'b0;
    #2;
    chk("abe_off", 1'b0, addr_grp_oe);
    @(posedge hclk);
    address_drive_enable <= 1'b1;
    #2;
    chk("abe_on", 1'b1, addr_grp_oe);
    conclude();
  end
endmodule : cemb_top_tb_top

// ==== verilog/cemb_pkg.sv ====
/*
  shared constants for the external memory bus engine: register offsets,
  field positions, reset values and the bus sequencer states.
  assumes a 32-bit ahb-lite slave decoding haddr[7:0].
*/
package cemb_pkg;
  // register byte offsets
  localparam logic [7:0] CEMB_OFS_ADDR = 8'h00;
  localparam logic [7:0] CEMB_OFS_WDATA = 8'h04;
  localparam logic [7:0] CEMB_OFS_CTRL = 8'h08;
  localparam logic [7:0] CEMB_OFS_STATUS = 8'h0C;
  localparam logic [7:0] CEMB_OFS_RDATA = 8'h10;
  localparam logic [7:0] CEMB_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] CEMB_OFS_IRQ_MASK = 8'h18;
  // control fields
  localparam int CEMB_CTRL_START = 0;
  localparam int CEMB_CTRL_WRITE = 1;
  localparam int CEMB_CTRL_WORD = 2;
  localparam int CEMB_CTRL_LOCK = 3;
  localparam logic [3:0] CEMB_CTRL_RST = 4'h4;
  // status fields
  localparam int CEMB_ST_BUSY = 0;
  localparam int CEMB_ST_ABORT = 1;
  localparam int CEMB_ST_PEND = 2;
  localparam int CEMB_ST_FAST = 3;
  // interrupt status / mask fields
  localparam int CEMB_IRQ_DONE = 0;
  localparam int CEMB_IRQ_ABORT = 1;
  localparam logic [1:0] CEMB_IRQ_RST = 2'h0;
  // pin synchroniser reset: mclk low, extend released, latch open
  localparam logic [3:0] CEMB_PIN_RST = 4'h6;
  typedef enum logic [1:0] {
    CEMB_IDLE,
    CEMB_REQ,
    CEMB_ACC,
    CEMB_DONE
  } cemb_state_t;
endpackage : cemb_pkg

// ==== verilog/cemb_top.sv ====
/*
  external memory bus engine: software queues single accesses over
  ahb-lite and the engine runs them on the pin bus, timed from mclk.
  assumes mclk is much slower than hclk (at least 4 hclk per phase);
  all pin inputs except the two drive enables are synchronised.
*/
// The address map and register access over AHB-Lite were chosen for this implementation.
module cemb_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic mclk,
  input wire logic ale,
  input wire logic cycle_extend_n,
  input wire logic abort,
  input wire logic address_drive_enable,
  input wire logic data_drive_enable,
  output logic [31:0] addr_out,
  output logic write_not_read,
  output logic word_not_byte,
  output logic lock,
  output logic addr_grp_oe,
  output logic memory_request_n,
  output logic core_fast_sel,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_oe
);
  logic [35:0] pin_s1_r;
  logic [35:0] pin_s2_r;
  logic mclk_d_r;
  logic mclk_s;
  logic ale_s;
  logic ext_n_s;
  logic abort_s;
  logic [31:0] data_s;
  logic mclk_rise;
  logic mclk_fall;
  logic wr_en_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_val;
  logic [31:0] acc_addr_r;
  logic [31:0] acc_wdata_r;
  logic [3:0] ctrl_r;
  logic [31:0] rdata_r;
  logic last_abort_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_set;
  logic irq_r;
  logic pending_r;
  logic start_req;
  logic busy;
  cemb_pkg::cemb_state_t st_r;
  logic [31:0] addr_int_r;
  logic rw_int_r;
  logic bw_int_r;
  logic lock_int_r;
  logic [31:0] addr_out_r;
  logic rw_out_r;
  logic bw_out_r;
  logic lock_out_r;
  logic mreq_n_r;
  logic fast_r;
  logic data_drv_r;
  logic done_ev;
  logic abort_ev;

  // two-stage synchronisers; only stage two is read by logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= {cemb_pkg::CEMB_PIN_RST, 32'h00000000};
      pin_s2_r <= {cemb_pkg::CEMB_PIN_RST, 32'h00000000};
      mclk_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {mclk, ale, cycle_extend_n, abort, data_in};
      pin_s2_r <= pin_s1_r;
      mclk_d_r <= pin_s2_r[35];
    end
  end

  assign mclk_s = pin_s2_r[35];
  assign ale_s = pin_s2_r[34];
  assign ext_n_s = pin_s2_r[33];
  assign abort_s = pin_s2_r[32];
  assign data_s = pin_s2_r[31:0];
  assign mclk_rise = mclk_s && !mclk_d_r;
  assign mclk_fall = !mclk_s && mclk_d_r;

  // ahb address phase capture; reads are prepared here so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_en_r <= hsel && htrans[1] && hwrite && hready;
      if (hsel && hready) begin
        wr_addr_r <= haddr[7:0];
      end
      if (hsel && htrans[1] && !hwrite && hready) begin
        hrdata_r <= rd_val;
      end
    end
  end

  // read decode; unmapped offsets read zero
  always_comb begin
    rd_val = 32'h00000000;
    if (haddr[7:0] == cemb_pkg::CEMB_OFS_ADDR) begin
      rd_val = acc_addr_r;
    end else if (haddr[7:0] == cemb_pkg::CEMB_OFS_WDATA) begin
      rd_val = acc_wdata_r;
    end else if (haddr[7:0] == cemb_pkg::CEMB_OFS_CTRL) begin
      rd_val = {28'h0000000, ctrl_r};
    end else if (haddr[7:0] == cemb_pkg::CEMB_OFS_STATUS) begin
      rd_val = {28'h0000000, fast_r, pending_r, last_abort_r, busy};
    end else if (haddr[7:0] == cemb_pkg::CEMB_OFS_RDATA) begin
      rd_val = rdata_r;
    end else if (haddr[7:0] == cemb_pkg::CEMB_OFS_IRQ_STAT) begin
      rd_val = {30'h00000000, irq_stat_r};
    end else if (haddr[7:0] == cemb_pkg::CEMB_OFS_IRQ_MASK) begin
      rd_val = {30'h00000000, irq_mask_r};
    end
  end

  // software registers; start bit is a pulse and never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_addr_r <= 32'h00000000;
      acc_wdata_r <= 32'h00000000;
      ctrl_r <= cemb_pkg::CEMB_CTRL_RST;
      irq_mask_r <= cemb_pkg::CEMB_IRQ_RST;
    end else if (wr_en_r && !busy) begin
      if (wr_addr_r == cemb_pkg::CEMB_OFS_ADDR) begin
        acc_addr_r <= hwdata;
      end else if (wr_addr_r == cemb_pkg::CEMB_OFS_WDATA) begin
        acc_wdata_r <= hwdata;
      end else if (wr_addr_r == cemb_pkg::CEMB_OFS_CTRL) begin
        ctrl_r <= {hwdata[3:1], 1'b0};
      end else if (wr_addr_r == cemb_pkg::CEMB_OFS_IRQ_MASK) begin
        irq_mask_r <= hwdata[1:0];
      end
    end else if (wr_en_r && wr_addr_r == cemb_pkg::CEMB_OFS_IRQ_MASK) begin
      irq_mask_r <= hwdata[1:0];
    end
  end

  assign start_req = wr_en_r && !busy && (wr_addr_r == cemb_pkg::CEMB_OFS_CTRL)
    && hwdata[cemb_pkg::CEMB_CTRL_START];
  assign busy = pending_r || (st_r != cemb_pkg::CEMB_IDLE);

  // sticky events: a set in the clearing cycle wins
  assign irq_set = {abort_ev, done_ev};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= cemb_pkg::CEMB_IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      if (wr_en_r && wr_addr_r == cemb_pkg::CEMB_OFS_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~hwdata[1:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // pending flag holds a start until the next mclk low phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_r <= 1'b0;
    end else if (start_req) begin
      pending_r <= 1'b1;
    end else if (st_r == cemb_pkg::CEMB_IDLE && mclk_fall) begin
      pending_r <= 1'b0;
    end
  end

  // bus sequencer, stepped only by synchronised mclk edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= cemb_pkg::CEMB_IDLE;
      mreq_n_r <= 1'b1;
      fast_r <= 1'b1;
      data_drv_r <= 1'b0;
      addr_int_r <= 32'h00000000;
      rw_int_r <= 1'b0;
      bw_int_r <= 1'b1;
      lock_int_r <= 1'b0;
      rdata_r <= 32'h00000000;
      last_abort_r <= 1'b0;
    end else begin
      case (st_r)
        cemb_pkg::CEMB_IDLE: begin
          if (mclk_fall && pending_r) begin
            mreq_n_r <= 1'b0;
            fast_r <= 1'b0;
            st_r <= cemb_pkg::CEMB_REQ;
          end
          if (mclk_rise && !ctrl_r[cemb_pkg::CEMB_CTRL_LOCK]) begin
            lock_int_r <= 1'b0;
          end
        end
        cemb_pkg::CEMB_REQ: begin
          if (mclk_rise) begin
            addr_int_r <= acc_addr_r;
            rw_int_r <= ctrl_r[cemb_pkg::CEMB_CTRL_WRITE];
            bw_int_r <= ctrl_r[cemb_pkg::CEMB_CTRL_WORD];
            lock_int_r <= ctrl_r[cemb_pkg::CEMB_CTRL_LOCK];
            st_r <= cemb_pkg::CEMB_ACC;
          end
        end
        cemb_pkg::CEMB_ACC: begin
          if (mclk_fall) begin
            data_drv_r <= rw_int_r;
            if (ext_n_s) begin
              if (!rw_int_r) begin
                rdata_r <= data_s;
              end
              last_abort_r <= abort_s;
              mreq_n_r <= 1'b1;
              st_r <= cemb_pkg::CEMB_DONE;
            end
          end
        end
        cemb_pkg::CEMB_DONE: begin
          if (mclk_rise) begin
            data_drv_r <= 1'b0;
            fast_r <= 1'b1;
            st_r <= cemb_pkg::CEMB_IDLE;
          end
        end
        default: begin
          st_r <= cemb_pkg::CEMB_IDLE;
        end
      endcase
    end
  end

  assign done_ev = (st_r == cemb_pkg::CEMB_DONE) && mclk_rise;
  assign abort_ev = (st_r == cemb_pkg::CEMB_ACC) && mclk_fall && ext_n_s && abort_s;

  // output latches, transparent while ale is high; ale is a pin so it is
  // synchronised, which delays the hold by two hclk cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_out_r <= 32'h00000000;
      rw_out_r <= 1'b0;
      bw_out_r <= 1'b1;
      lock_out_r <= 1'b0;
    end else if (ale_s) begin
      addr_out_r <= addr_int_r;
      rw_out_r <= rw_int_r;
      bw_out_r <= bw_int_r;
      lock_out_r <= lock_int_r;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_r;
  assign addr_out = addr_out_r;
  assign write_not_read = rw_out_r;
  assign word_not_byte = bw_out_r;
  assign lock = lock_out_r;
  assign memory_request_n = mreq_n_r;
  assign core_fast_sel = fast_r;
  assign data_out = acc_wdata_r;
  // enables bypass the clock so another master can take the bus at once
  assign addr_grp_oe = address_drive_enable;
  assign data_oe = data_drive_enable && data_drv_r;

  sequence seq_req_start;
    $fell(mreq_n_r);
  endsequence
  sequence seq_slow_core;
    !mclk_s && !fast_r;
  endsequence

  chk_addr_float: assert property (@(posedge hclk) disable iff (!hresetn)
    !address_drive_enable |-> !addr_grp_oe) else $error("address group driven while disabled");
  chk_abort_window: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq_stat_r[1]) |-> $past(st_r) == cemb_pkg::CEMB_ACC)
    else $error("abort taken outside an access");
  chk_addr_change_high: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(addr_int_r) |-> mclk_s) else $error("address changed with mclk low");
  chk_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !ale_s |=> $stable(addr_out_r) && $stable(lock_out_r))
    else $error("latched outputs moved while held");
  chk_write_data_low: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(data_drv_r) |-> !mclk_s && rw_int_r) else $error("write drive not in low phase");
  chk_data_only_write: assert property (@(posedge hclk) disable iff (!hresetn)
    data_oe |-> rw_int_r && st_r != cemb_pkg::CEMB_IDLE)
    else $error("data driven outside a write");
  chk_data_float: assert property (@(posedge hclk) disable iff (!hresetn)
    !data_drive_enable |-> !data_oe) else $error("data driven while disabled");
  chk_lock_change_high: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(lock_int_r) |-> mclk_s) else $error("lock changed with mclk low");
  chk_mreq_slow_core: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_req_start |-> seq_slow_core) else $error("request not in low phase or core fast");
  chk_fast_when_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    done_ev |=> fast_r && st_r == cemb_pkg::CEMB_IDLE) else $error("core not back on fast clock");
  chk_width_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == cemb_pkg::CEMB_REQ) && mclk_rise |=> bw_int_r == ctrl_r[cemb_pkg::CEMB_CTRL_WORD])
    else $error("width qualifier wrong");
endmodule : cemb_top
